// *** inc/line_test_ed_pkg.sv ***
// Constants for the self-test extension and energy-detect control registers.
// Assumes a 40 MHz system clock and a 5-bit management register address.
package line_test_ed_pkg;

  // Register addresses on the management register port
  localparam logic [4:0]  SELFTEST_EXT_ADDR   = 5'h1b;
  localparam logic [4:0]  ED_CONTROL_ADDR     = 5'h1d;

  // Self-test extension field positions
  localparam int          ERR_COUNT_LSB       = 8;
  localparam int          ERR_COUNT_MSB       = 15;
  localparam int          RSVD_HI_LSB         = 6;
  localparam int          RSVD_HI_MSB         = 7;
  localparam int          CONT_MODE_BIT       = 5;
  localparam int          PATT_EN_BIT         = 4;
  localparam int          RSVD_LO_BIT         = 3;
  localparam int          PATT_GAP_BIT        = 2;
  localparam int          PATT_SEL_LSB        = 0;
  localparam int          PATT_SEL_MSB        = 1;

  // Energy-detect control field positions
  localparam int          ENERGY_DETECT_ENABLE_BIT           = 15;
  localparam int          AUTO_UP_BIT         = 14;
  localparam int          AUTO_DOWN_BIT       = 13;
  localparam int          MANUAL_BIT          = 12;
  localparam int          PWR_STATE_BIT       = 10;
  localparam int          DATA_THR_LSB        = 0;
  localparam int          DATA_THR_MSB        = 3;

  // Values after reset, and the error count limit
  localparam logic [7:0]  ERR_COUNT_RST       = 8'h00;
  localparam logic [7:0]  ERR_COUNT_MAX       = 8'hff;
  localparam logic [1:0]  PATT_SEL_RST        = 2'h0;
  localparam logic        AUTO_UP_RST         = 1'b1;
  localparam logic        AUTO_DOWN_RST       = 1'b1;
  localparam logic [3:0]  DATA_THR_RST        = 4'h1;

  // Pattern select codes
  localparam logic [1:0]  PATT_DATA_EOP_A     = 2'h0;
  localparam logic [1:0]  PATT_DATA_EOP_B     = 2'h1;
  localparam logic [1:0]  PATT_LINK_PULSES    = 2'h2;
  localparam logic [1:0]  PATT_MANCH_ONES     = 2'h3;

  // Timing: clock rate and documented intervals
  localparam int          CLK_MHZ             = 40;
  localparam int          GAP_SHORT_US        = 10;
  localparam int          GAP_LONG_US         = 15;
  localparam int          GAP_SHORT_CYCLES    = GAP_SHORT_US * CLK_MHZ;
  localparam int          GAP_LONG_CYCLES     = GAP_LONG_US * CLK_MHZ;
  localparam int          IDLE_RESET_S        = 2;
  localparam int          IDLE_RESET_CYCLES   = IDLE_RESET_S * CLK_MHZ * 1000000;

  // Energy-detect power state machine, Gray coded around the loop
  typedef enum logic [1:0] {
    ED_DOWN     = 2'b00,
    ED_UP_SEQ   = 2'b01,
    ED_UP       = 2'b11,
    ED_DOWN_SEQ = 2'b10
  } ed_state_t;

endpackage : line_test_ed_pkg

// *** sim/line_test_ed_ctrl_props.sv ***
// Checker for the register port and energy-detect outputs of the block.
// Assumes one clock domain and the package constants of the design.
`timescale 1ns/1ps
module line_test_ed_ctrl_props
  import line_test_ed_pkg::*;
#(
  parameter int IDLE_CYCLES = 50  // Quiet time, as in the block
)
(
  input wire logic        clk_sys,            // System clock
  input wire logic        rst_n,              // Reset, active low
  input wire logic [4:0]  reg_addr,           // Register address
  input wire logic        reg_wr,             // Write strobe
  input wire logic [15:0] reg_wdata,          // Write data
  input wire logic        selftest_active,    // Self-test running
  input wire logic        continuous_tx,      // Gapless transmission
  input wire logic        pattern_gen_on,     // Generator on
  input wire logic [1:0]  pattern_select,     // Pattern choice
  input wire logic [9:0]  pattern_gap_cycles, // Gap length
  input wire logic        ed_mode_on,         // Energy detect on
  input wire logic        powered_up_flag,    // Powered up
  input wire logic        power_up_start,     // Power-up pulse
  input wire logic        power_down_start    // Power-down pulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire wr_ext = reg_wr && reg_addr == SELFTEST_EXT_ADDR;  // Write to self-test register
  wire wr_ed  = reg_wr && reg_addr == ED_CONTROL_ADDR;    // Write to energy-detect register
  wire idle   = ed_mode_on && !power_up_start && !power_down_start; // Settled state
  logic cont_seen;  // Continuous bit as last written
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      cont_seen <= 1'b0;
    else if (wr_ext)
      cont_seen <= reg_wdata[CONT_MODE_BIT];
  end
  property p_gap;
    wr_ext |=> pattern_gap_cycles == ($past(reg_wdata[2]) ? 10'h258 : 10'h190);
  endproperty
  property p_pen;
    wr_ext |=> pattern_gen_on == $past(reg_wdata[4]);
  endproperty
  property p_sel;
    wr_ext |=> pattern_select == $past(reg_wdata[1:0]);
  endproperty
  property p_en;
    wr_ed |=> ed_mode_on == $past(reg_wdata[15]);
  endproperty
  property p_man_dn;
    wr_ed && reg_wdata[15] && reg_wdata[12] && idle && powered_up_flag
      |-> ##2 power_down_start ##1 !powered_up_flag;
  endproperty
  property p_man_up;
    wr_ed && reg_wdata[15] && reg_wdata[12] && idle && !powered_up_flag
      |-> ##2 power_up_start ##1 powered_up_flag;
  endproperty
  property p_up_seq;
    power_up_start |=> !power_up_start && powered_up_flag;
  endproperty
  property p_dn_seq;
    power_down_start ##1 ed_mode_on |-> !powered_up_flag && !power_down_start;
  endproperty
  property p_dis;
    !ed_mode_on [*2] |=> powered_up_flag && !power_up_start && !power_down_start;
  endproperty
  property p_cont;
    continuous_tx == (cont_seen && selftest_active);
  endproperty
  a_gap: assert property (p_gap) else $error("gap length wrong");
  a_pen: assert property (p_pen) else $error("generator enable wrong");
  a_sel: assert property (p_sel) else $error("pattern select wrong");
  a_en: assert property (p_en) else $error("energy detect enable wrong");
  a_man_dn: assert property (p_man_dn) else $error("manual power down missed");
  a_man_up: assert property (p_man_up) else $error("manual power up missed");
  a_up_seq: assert property (p_up_seq) else $error("power-up sequence wrong");
  a_dn_seq: assert property (p_dn_seq) else $error("power-down sequence wrong");
  a_dis: assert property (p_dis) else $error("disabled state wrong");
  a_cont: assert property (p_cont) else $error("continuous without self-test");
  c_up: cover property (power_up_start);
  c_dn: cover property (power_down_start);
  c_cont: cover property (continuous_tx);
endmodule : line_test_ed_ctrl_props
bind line_test_ed_ctrl line_test_ed_ctrl_props #(.IDLE_CYCLES(IDLE_CYCLES)) line_test_ed_ctrl_props_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .selftest_active(selftest_active), .continuous_tx(continuous_tx), .pattern_gen_on(pattern_gen_on),
  .pattern_select(pattern_select), .pattern_gap_cycles(pattern_gap_cycles), .ed_mode_on(ed_mode_on),
  .powered_up_flag(powered_up_flag), .power_up_start(power_up_start), .power_down_start(power_down_start));

// *** sim/mgmt_ctrl_model.sv ***
// Management controller model: single-word writes and reads of the block.
// Assumes strobes are taken on the rising edge of clk_sys.
// Jabber guard and crossover live elsewhere; the bench never needs them.
`timescale 1ns/1ps
module mgmt_ctrl_model
(
  input  wire logic        clk_sys,   // System clock
  output logic      [4:0]  reg_addr,  // Register address
  output logic             reg_wr,    // Write strobe
  output logic             reg_rd,    // Read strobe
  output logic      [15:0] reg_wdata, // Write data
  input  wire logic [15:0] reg_rdata  // Read data
);
  initial
  begin
    reg_addr  = 5'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 16'h0000;
  end
  // One write; reserved self-test bits always go out as zero
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #2;
    reg_addr  = a;
    reg_wdata = (a == 5'h1b) ? (d & 16'hff37) : d;
    reg_wr    = 1'b1;
    @(posedge clk_sys);
    #2;
    reg_wr    = 1'b0;
    reg_addr  = ~reg_addr;   // Released lines lose their value
    reg_wdata = ~reg_wdata;
  endtask : wr
  // One read; data taken once the strobe edge has passed
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    #2;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk_sys);
    #2;
    d        = reg_rdata;
    reg_rd   = 1'b0;
    reg_addr = ~reg_addr;
  endtask : rd
endmodule : mgmt_ctrl_model

// *** sim/tb_line_test_ed_ctrl.sv ***
// Self-checking bench for the self-test and energy-detect registers.
// Assumes the management model sits on the register port.
`timescale 1ns/1ps
module tb_line_test_ed_ctrl
  import line_test_ed_pkg::*;
;
  logic        clk_sys = 1'b0;               // System clock
  logic        rst_n = 1'b0;                 // Reset, active low
  logic        selftest_start = 1'b0;        // Self-test restart
  logic        selftest_active = 1'b0;       // Self-test running
  logic        nibble_err = 1'b0;            // Errored nibble
  logic        ed_data_event_pin = 1'b0;     // Data event pin
  logic        line_energy_pin = 1'b1;       // Line energy pin
  logic [4:0]  reg_addr;                     // Register port
  logic        reg_wr, reg_rd;               // Strobes
  logic [15:0] reg_wdata, reg_rdata, d, q;   // Data words
  logic        continuous_tx, pattern_gen_on, ed_mode_on, powered_up_flag, power_up_start, power_down_start;
  logic [1:0]  pattern_select;               // Pattern choice
  logic [9:0]  pattern_gap_cycles;           // Gap length
  integer      seed = 32'hb4f56553;          // Fixed random seed
  int          errors = 0, checks = 0, cycles_run = 0, n, k;
  line_test_ed_ctrl #(.IDLE_CYCLES(50)) line_test_ed_ctrl_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .selftest_start(selftest_start),
    .selftest_active(selftest_active), .nibble_err(nibble_err), .continuous_tx(continuous_tx),
    .pattern_gen_on(pattern_gen_on), .pattern_select(pattern_select), .pattern_gap_cycles(pattern_gap_cycles),
    .ed_data_event_pin(ed_data_event_pin), .line_energy_pin(line_energy_pin), .ed_mode_on(ed_mode_on),
    .powered_up_flag(powered_up_flag), .power_up_start(power_up_start), .power_down_start(power_down_start));
  mgmt_ctrl_model mgmt_ctrl_model_inst (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // Hang guard
  always @(posedge clk_sys)
  begin
    cycles_run <= cycles_run + 1;
    if (cycles_run == 5000)
    begin
      errors = errors + 1;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checks = checks + 1;
    if (s !== e)
    begin
      errors = errors + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic cyc(input int c);
    repeat (c) @(posedge clk_sys);
    #2;
  endtask : cyc
  task automatic rdc(input logic [4:0] a, input logic [15:0] e, input string nm);
    mgmt_ctrl_model_inst.rd(a, q);
    chk(nm, q, e);
  endtask : rdc
  task automatic ev();
    ed_data_event_pin = 1'b1;
    cyc(2);
    ed_data_event_pin = 1'b0;
    cyc(2);
  endtask : ev
  // Waits a bounded time for a one-cycle pulse
  task automatic wait_pulse(ref logic p, input string nm);
    for (k = 0; k < 20 && p !== 1'b1; k++) cyc(1);
    chk(nm, 16'(p), 16'h0001);
    cyc(1);
  endtask : wait_pulse
  function automatic logic [9:0] exp_gap(input logic g);
    return g ? 10'(GAP_LONG_CYCLES) : 10'(GAP_SHORT_CYCLES);
  endfunction : exp_gap
  task automatic rst_chk();
    rst_n = 1'b0;
    cyc(20);
    rst_n = 1'b1;
    cyc(3);
    rdc(SELFTEST_EXT_ADDR, 16'h0000, "ext reset");
    rdc(ED_CONTROL_ADDR, 16'h6401, "ed reset");
    rdc(5'h05, 16'h0000, "unmapped");
  endtask : rst_chk
  initial
  begin
    rst_chk();
    for (n = 0; n < 8; n++)
    begin
      d = $random(seed);
      d[1:0] = n[1:0];
      mgmt_ctrl_model_inst.wr(SELFTEST_EXT_ADDR, d);
      rdc(SELFTEST_EXT_ADDR, {8'h00, d[7:0] & 8'h37}, "ext");
      chk("sel", 16'(pattern_select), 16'(d[1:0]));
      chk("gap", 16'(pattern_gap_cycles), 16'(exp_gap(d[2])));
      chk("pen", 16'(pattern_gen_on), 16'(d[4]));
    end
    // Self-test error count with continuous mode on
    mgmt_ctrl_model_inst.wr(SELFTEST_EXT_ADDR, 16'h0020);
    n = 1 + ($random(seed) & 63);
    selftest_active = 1'b1;
    selftest_start = 1'b1;
    cyc(1);
    selftest_start = 1'b0;
    chk("cont", 16'(continuous_tx), 16'h0001);
    nibble_err = 1'b1;
    cyc(n);
    selftest_active = 1'b0;
    cyc(3);
    nibble_err = 1'b0;
    chk("cont off", 16'(continuous_tx), 16'h0000);
    rdc(SELFTEST_EXT_ADDR, {n[7:0], 8'h20}, "count");
    selftest_active = 1'b1;
    selftest_start = 1'b1;
    nibble_err = 1'b1;
    cyc(1);
    selftest_start = 1'b0;
    nibble_err = 1'b0;
    rdc(SELFTEST_EXT_ADDR, 16'h0020, "restart");
    nibble_err = 1'b1;
    cyc(300);
    nibble_err = 1'b0;
    rdc(SELFTEST_EXT_ADDR, 16'hff20, "saturate");
    // Manual power changes, set by the manager when it chooses
    mgmt_ctrl_model_inst.wr(ED_CONTROL_ADDR, 16'h8001);
    chk("ed on", 16'(ed_mode_on), 16'h0001);
    mgmt_ctrl_model_inst.wr(ED_CONTROL_ADDR, 16'h9001);
    cyc(3);
    rdc(ED_CONTROL_ADDR, 16'h8001, "manual down");
    mgmt_ctrl_model_inst.wr(ED_CONTROL_ADDR, 16'h9001);
    cyc(3);
    rdc(ED_CONTROL_ADDR, 16'h8401, "manual up");
    // Automatic power down, then up at a threshold of two events
    mgmt_ctrl_model_inst.wr(ED_CONTROL_ADDR, 16'ha001);
    line_energy_pin = 1'b0;
    wait_pulse(power_down_start, "auto down");
    line_energy_pin = 1'b1;
    mgmt_ctrl_model_inst.wr(ED_CONTROL_ADDR, 16'hc002);
    ev();
    cyc(8);
    chk("one event", 16'(powered_up_flag), 16'h0000);
    ev();
    wait_pulse(power_up_start, "auto up");
    mgmt_ctrl_model_inst.wr(ED_CONTROL_ADDR, 16'hd002);
    cyc(3);
    ev();
    cyc(70);
    ev();
    cyc(8);
    chk("idle clear", 16'(powered_up_flag), 16'h0000);
    mgmt_ctrl_model_inst.wr(ED_CONTROL_ADDR, 16'h0000);
    cyc(3);
    chk("disabled", 16'(powered_up_flag), 16'h0001);
    chk("ed off", 16'(ed_mode_on), 16'h0000);
    rst_chk();
    print_verdict();
  end
endmodule : tb_line_test_ed_ctrl

// *** src/ed_event_counter.sv ***
// Energy-detect data event counter with idle timeout and threshold compare.
// Assumes event pulses are one cycle wide and already on clk_sys.
`timescale 1ns/1ps
module ed_event_counter
  import line_test_ed_pkg::*;
#(
  parameter int IDLE_CYCLES = IDLE_RESET_CYCLES  // Cycles without events before count resets
)
(
  input  wire logic       clk_sys,    // System clock
  input  wire logic       rst_n,      // Synchronous reset, active low
  input  wire logic       count_en,   // Counting allowed
  input  wire logic       clear,      // Restart count from zero
  input  wire logic       event_p,    // One data event, pulse
  input  wire logic [3:0] threshold,  // Events needed for action
  output logic            thr_met     // Count has reached threshold
);

  // Refuse settings the timer cannot serve
  if (IDLE_CYCLES < 1)
  begin : g_chk
    $error("ed_event_counter: IDLE_CYCLES must be at least one");
  end

  localparam int           TW        = $clog2(IDLE_CYCLES + 1);          // Timer width
  localparam logic [TW-1:0] IDLE_LAST = TW'(IDLE_CYCLES - 1);            // Final timer value

  logic [3:0]    count_reg;  // Saturating event count
  logic [TW-1:0] idle_reg;   // Cycles since last event

  // Idle timer restarts on each event
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || !count_en || clear || event_p)
      idle_reg <= '0;
    else if (idle_reg != IDLE_LAST)
      idle_reg <= idle_reg + TW'(1);
  end

  // Event count, saturating, dropped after a quiet interval
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || !count_en || clear)
      count_reg <= 4'h0;
    else if (event_p && count_reg != 4'hf)
      count_reg <= count_reg + 4'h1;
    else if (idle_reg == IDLE_LAST)
      count_reg <= 4'h0;
  end

  // Threshold reached once enough events are seen
  assign thr_met = count_en && (count_reg >= threshold);

endmodule : ed_event_counter

// *** src/line_test_ed_ctrl.sv ***
// Self-test extension and energy-detect control registers with their logic.
// Assumes a management register port on clk_sys; line pins are asynchronous.
`timescale 1ns/1ps
module line_test_ed_ctrl
  import line_test_ed_pkg::*;
#(
  parameter int IDLE_CYCLES = IDLE_RESET_CYCLES  // Quiet time before event count resets
)
(
  input  wire logic        clk_sys,          // System clock, 40 MHz
  input  wire logic        rst_n,            // Synchronous reset, active low
  // Management register port
  input  wire logic [4:0]  reg_addr,         // Register address
  input  wire logic        reg_wr,           // Write strobe, one cycle
  input  wire logic        reg_rd,           // Read strobe, one cycle
  input  wire logic [15:0] reg_wdata,        // Write data
  output logic      [15:0] reg_rdata,        // Read data, registered
  // Packet self-test
  input  wire logic        selftest_start,   // Self-test (re)start pulse
  input  wire logic        selftest_active,  // Self-test running
  input  wire logic        nibble_err,       // One errored data nibble, pulse
  output logic             continuous_tx,    // Gapless pseudo-random transmission
  // 10 Mb pattern generator
  output logic             pattern_gen_on,   // Pattern generator running
  output logic [1:0]       pattern_select,   // Pattern choice
  output logic [9:0]       pattern_gap_cycles, // Idle cycles between sequences
  // Energy detect, line side
  input  wire logic        ed_data_event_pin, // Energy-detect data event, async
  input  wire logic        line_energy_pin,  // Line energy present, async level
  output logic             ed_mode_on,       // Energy-detect mode enabled
  output logic             powered_up_flag,  // Energy detect powered up
  output logic             power_up_start,   // Begin power-up sequence, pulse
  output logic             power_down_start  // Begin power-down sequence, pulse
);

  // Refuse settings the idle timer cannot serve
  if (IDLE_CYCLES < 1)
  begin : g_chk
    $error("line_test_ed_ctrl: IDLE_CYCLES must be at least one");
  end

  // Gap lengths in system clock cycles
  localparam logic [9:0] GAP_SHORT = 10'(GAP_SHORT_CYCLES);   // 10 us in cycles
  localparam logic [9:0] GAP_LONG  = 10'(GAP_LONG_CYCLES);    // 15 us in cycles

  // Register fields
  logic [7:0]  err_count_reg;      // Self-test error count
  logic [1:0]  rsvd_hi_reg;        // Reserved bits 7:6, stored as written
  logic        rsvd_lo_reg;        // Reserved bit 3, stored as written
  logic        cont_mode_reg;      // Continuous self-test mode
  logic        patt_en_reg;        // Pattern generator enable
  logic        patt_gap_reg;       // Long gap select
  logic [1:0]  patt_sel_reg;       // Pattern select
  logic        energy_detect_enable_reg;          // Energy-detect enable
  logic        auto_up_reg;        // Automatic power up
  logic        auto_down_reg;      // Automatic power down
  logic        manual_reg;         // Manual power toggle request
  logic [3:0]  data_thr_reg;       // Data event threshold
  ed_state_t   state_reg;          // Energy-detect power state
  ed_state_t   state_next;         // Next power state

  // Synchronisers for line inputs
  logic        evt_s1_reg;         // Event pin, first stage
  logic        evt_s2_reg;         // Event pin, second stage
  logic        evt_s3_reg;         // Event pin, delayed for edge
  logic        nrg_s1_reg;         // Energy pin, first stage
  logic        nrg_s2_reg;         // Energy pin, second stage
  logic        evt_pulse;          // Rising edge of data event
  logic        thr_met;            // Data threshold reached
  logic        wr_ext;             // Write to self-test extension
  logic        wr_ed;              // Write to energy-detect control
  logic        rd_ext;             // Read of self-test extension
  logic        rd_ed;              // Read of energy-detect control
  logic [9:0]  gap_cycles_reg;     // Gap length in cycles, registered

  // Strobe decode for the two mapped addresses; writes to other addresses are ignored, reads return zero
  assign wr_ext = reg_wr && (reg_addr == SELFTEST_EXT_ADDR);
  assign wr_ed  = reg_wr && (reg_addr == ED_CONTROL_ADDR);
  assign rd_ext = reg_rd && (reg_addr == SELFTEST_EXT_ADDR);
  assign rd_ed  = reg_rd && (reg_addr == ED_CONTROL_ADDR);

  // Event pin synchroniser; the third stage only delays the settled level
  // so that a rising edge is found without reading the first stage
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      evt_s1_reg <= 1'b0;
      evt_s2_reg <= 1'b0;
      evt_s3_reg <= 1'b0;
    end
    else
    begin
      evt_s1_reg <= ed_data_event_pin;
      evt_s2_reg <= evt_s1_reg;
      evt_s3_reg <= evt_s2_reg;
    end
  end

  // Line energy synchroniser; only the second stage feeds the power logic
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      nrg_s1_reg <= 1'b0;
      nrg_s2_reg <= 1'b0;
    end
    else
    begin
      nrg_s1_reg <= line_energy_pin;
      nrg_s2_reg <= nrg_s1_reg;
    end
  end

  // One-cycle pulse on each synchronised rising edge of the event pin
  assign evt_pulse = evt_s2_reg && !evt_s3_reg;

  // Self-test error counter; a restart wins over an error in the same cycle
  // Counting only while self-test runs keeps stray line errors out
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      err_count_reg <= ERR_COUNT_RST;
    else if (selftest_start)
      err_count_reg <= ERR_COUNT_RST;
    else if (selftest_active && nibble_err && err_count_reg != ERR_COUNT_MAX)
      err_count_reg <= err_count_reg + 8'h01;
  end

  // Self-test extension writable fields
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rsvd_hi_reg   <= 2'h0;
      rsvd_lo_reg   <= 1'b0;
      cont_mode_reg <= 1'b0;
      patt_en_reg   <= 1'b0;
      patt_gap_reg  <= 1'b0;
      patt_sel_reg  <= PATT_SEL_RST;
    end
    else if (wr_ext)
    begin
      // Reserved bits are kept as written; the manager should send zero
      rsvd_hi_reg   <= reg_wdata[RSVD_HI_MSB:RSVD_HI_LSB];
      rsvd_lo_reg   <= reg_wdata[RSVD_LO_BIT];
      cont_mode_reg <= reg_wdata[CONT_MODE_BIT];
      patt_en_reg   <= reg_wdata[PATT_EN_BIT];
      patt_gap_reg  <= reg_wdata[PATT_GAP_BIT];
      patt_sel_reg  <= reg_wdata[PATT_SEL_MSB:PATT_SEL_LSB];
    end
  end

  // Gap length follows the gap bit; held in a register so the output is clean
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      gap_cycles_reg <= GAP_SHORT;
    else if (wr_ext)
      gap_cycles_reg <= reg_wdata[PATT_GAP_BIT] ? GAP_LONG : GAP_SHORT;
  end

  // Energy-detect control writable fields
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      energy_detect_enable_reg     <= 1'b0;
      auto_up_reg   <= AUTO_UP_RST;
      auto_down_reg <= AUTO_DOWN_RST;
      data_thr_reg  <= DATA_THR_RST;
    end
    else if (wr_ed)
    begin
      energy_detect_enable_reg     <= reg_wdata[ENERGY_DETECT_ENABLE_BIT];
      auto_up_reg   <= reg_wdata[AUTO_UP_BIT];
      auto_down_reg <= reg_wdata[AUTO_DOWN_BIT];
      data_thr_reg  <= reg_wdata[DATA_THR_MSB:DATA_THR_LSB];
    end
  end

  // Manual toggle: set by a write of one, cleared in the next cycle whether acted on or not
  // It reads back as one only in the cycle after the write
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      manual_reg <= 1'b0;
    else if (wr_ed && reg_wdata[MANUAL_BIT])
      manual_reg <= 1'b1;
    else
      manual_reg <= 1'b0;
  end

  // Data event counter with idle timeout, restarted on entering power-up
  // Restarting there makes the next automatic power-up need a fresh run
  // of events once the line has gone quiet again
  ed_event_counter #(
    .IDLE_CYCLES (IDLE_CYCLES)
  ) u_evt_cnt (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .count_en  (energy_detect_enable_reg),
    .clear     (state_reg == ED_UP_SEQ),
    .event_p   (evt_pulse),
    .threshold (data_thr_reg),
    .thr_met   (thr_met)
  );

  // Power state decision
  // Gray-coded loop: down, up sequence, up, down sequence, down again
  // Each sequence state lasts one cycle and carries its start pulse
  // A manual request wins over the automatic triggers and needs no threshold
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ED_DOWN:
      begin
        if (manual_reg)
          state_next = ED_UP_SEQ;
        else if (auto_up_reg && thr_met)
          state_next = ED_UP_SEQ;
      end
      ED_UP_SEQ:
        state_next = ED_UP;
      ED_UP:
      begin
        if (manual_reg)
          state_next = ED_DOWN_SEQ;
        else if (auto_down_reg && !nrg_s2_reg)
          state_next = ED_DOWN_SEQ;
      end
      ED_DOWN_SEQ:
        state_next = ED_DOWN;
      default:
        state_next = ED_DOWN;
    endcase
  end

  // Power state register; with energy detect off the device stays powered
  // Parking in the powered state keeps the transceiver running; the flag
  // carries no meaning while energy detect is disabled
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      state_reg <= ED_DOWN;
    else if (!energy_detect_enable_reg)
      state_reg <= ED_UP;
    else
      state_reg <= state_next;
  end

  // Register read-back, zero for other addresses
  // A read in the same cycle as a write returns the old contents
  // The data word holds until the next read strobe
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (rd_ext)
      reg_rdata <= {err_count_reg, rsvd_hi_reg, cont_mode_reg, patt_en_reg,
                    rsvd_lo_reg, patt_gap_reg, patt_sel_reg};
    else if (rd_ed)
      reg_rdata <= {energy_detect_enable_reg, auto_up_reg, auto_down_reg, manual_reg, 1'b0,
                    powered_up_flag, 6'h00, data_thr_reg};
    else if (reg_rd)
      reg_rdata <= 16'h0000;
  end

  // Outputs to the transmit logic; continuous sending needs a running self-test
  assign continuous_tx      = cont_mode_reg && selftest_active;
  assign pattern_gen_on     = patt_en_reg;
  assign pattern_select     = patt_sel_reg;
  assign pattern_gap_cycles = gap_cycles_reg;

  // Outputs to the power logic; start pulses are held off while disabled
  assign ed_mode_on         = energy_detect_enable_reg;
  assign powered_up_flag    = (state_reg == ED_UP);
  assign power_up_start     = energy_detect_enable_reg && (state_reg == ED_UP_SEQ);
  assign power_down_start   = energy_detect_enable_reg && (state_reg == ED_DOWN_SEQ);

endmodule : line_test_ed_ctrl
